// File: dv/bad_bus_model.sv
module bad_bus_model (
   // Request from the bench.
   input  wire logic        clk_i,
   input  wire logic        req_i,
   input  wire logic [31:0] req_addr_i,
   // Processor address bus.
   output logic             addr_valid_o,
   output logic [31:0]      addr_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [31:0] last_reg = 32'h0;
   // Idle bus shows the inverse of the last address, never a stale copy.
   always_ff @(posedge clk_i) begin
      if (req_i) last_reg <= req_addr_i;
   end
   assign addr_valid_o = req_i;
   assign addr_o       = req_i ? req_addr_i : ~last_reg;
endmodule

// File: dv/bad_decoder_chk.sv
module bad_decoder_chk (
   // Clock, reset and request.
   input wire logic        clk_i,
   input wire logic        rst_b_i,
   input wire logic        addr_valid_i,
   input wire logic [31:0] addr_i,
   // Decode results.
   input wire logic [5:0]  mem_cs_b_o,
   input wire logic [3:0]  dram_bank_sel_o,
   input wire logic [3:0]  target_o,
   input wire logic        progio_sel_o,
   input wire logic        miss_o,
   input wire logic [31:0] dram_base0_o,
   input wire logic [31:0] dram_base1_o,
   input wire logic [31:0] dram_mask_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   // Counts edges since reset release so the static outputs are judged only once settled.
   logic [1:0] up_cnt_reg;
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) up_cnt_reg <= 2'h0;
      else if (up_cnt_reg != 2'h3) up_cnt_reg <= up_cnt_reg + 2'h1;
   end
   // A request anywhere in the serial controller window.
   sequence s_scc_req;
      addr_valid_i && addr_i[31:25] == 7'h0b;
   endsequence
   // The registered answer to a serial controller request.
   sequence s_scc_ans;
      mem_cs_b_o == 6'h1f && target_o == 4'h3;
   endsequence
   // A request inside the I/O controller window.
   sequence s_io_req;
      addr_valid_i && addr_i inside {[32'h1800_0600:32'h1800_0608]};
   endsequence
   // A request inside PCI memory space 1 or 2.
   sequence s_pcim_req;
      addr_valid_i && addr_i[31:30] == 2'h1;
   endsequence
   // Never more than one select, and the unused lines stay negated.
   property p_one_select;
      $countones(~mem_cs_b_o) <= 1 && mem_cs_b_o[4:2] == 3'h7;
   endproperty
   // No request gives no select, no miss and no target.
   property p_idle_quiet;
      !addr_valid_i |=> mem_cs_b_o == 6'h3f && !miss_o && target_o == 4'h0;
   endproperty
   // The boot select only answers a request in the boot range.
   property p_boot_cause;
      !mem_cs_b_o[0] |-> $past(addr_valid_i) && $past(addr_i[31:22]) == 10'h07f;
   endproperty
   // The static RAM select only answers a request in the first megabyte.
   property p_sram_cause;
      !mem_cs_b_o[1] |-> $past(addr_valid_i) && $past(addr_i) <= 32'h000f_ffff;
   endproperty
   // Address bit 29 tells memory space 2 from memory space 1.
   property p_pci_mem;
      s_pcim_req |=> target_o == ($past(addr_i[29]) ? 4'h9 : 4'h8);
   endproperty
   // A bank select is one-hot and only stands for a DRAM access.
   property p_bank_onehot;
      |dram_bank_sel_o |-> $onehot(dram_bank_sel_o) && target_o == 4'h4 && !miss_o;
   endproperty
   // Once settled, the first DRAM base and the DRAM mask stand still until the next reset.
   property p_cfg_frozen;
      up_cnt_reg == 2'h3 |-> $stable(dram_base0_o) && $stable(dram_mask_o);
   endproperty
   // A wide bank stride comes with the wide mask, a narrow one with the narrow mask.
   property p_mask_stride;
      up_cnt_reg == 2'h3 |-> dram_mask_o == ((dram_base1_o - dram_base0_o == 32'h0200_0000)
         ? 32'hfe00_0000 : 32'hff80_0000);
   endproperty
   a_scc_select: assert property (s_scc_req |=> s_scc_ans)
      else $error("serial controller select missing");
   a_one_select: assert property (p_one_select)
      else $error("more than one select active");
   a_idle_quiet: assert property (p_idle_quiet)
      else $error("select without a request");
   a_boot_cause: assert property (p_boot_cause)
      else $error("boot select outside boot range");
   a_sram_cause: assert property (p_sram_cause)
      else $error("static ram select outside its range");
   a_io_window: assert property (s_io_req |=> progio_sel_o && mem_cs_b_o == 6'h3f)
      else $error("io controller window not decoded");
   a_pci_mem_win: assert property (p_pci_mem)
      else $error("pci memory window wrong");
   a_bank_onehot: assert property (p_bank_onehot)
      else $error("dram bank select not one-hot");
   a_cfg_frozen: assert property (p_cfg_frozen)
      else $error("dram setup moved after reset");
   a_mask_stride: assert property (p_mask_stride)
      else $error("bank mask does not match stride");
endmodule

bind bad_decoder bad_decoder_chk u_chk (
   .clk_i(clk_i), .rst_b_i(rst_b_i), .addr_valid_i(addr_valid_i), .addr_i(addr_i),
   .mem_cs_b_o(mem_cs_b_o), .dram_bank_sel_o(dram_bank_sel_o), .target_o(target_o),
   .progio_sel_o(progio_sel_o), .miss_o(miss_o), .dram_base0_o(dram_base0_o),
   .dram_base1_o(dram_base1_o), .dram_mask_o(dram_mask_o));

// File: dv/tb_bad_decoder.sv
module tb_bad_decoder;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_i = 0, rst_b_i = 0, req = 0, sd_in = 0, addr_valid, progio, miss, sdr;
   logic [3:0] cfg_in = 4'h0, cfg = 4'h0, bank, tgt;
   logic [31:0] req_addr = 0, addr, lo, st, b0, b1, b2, b3, msk, m3;
   logic [5:0] cs_b;
   logic [1:0] sock;
   int fails = 0, compares = 0;
   logic [3:0] cf[6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h8};
   logic [31:0] ad[32] = '{32'h0, 32'h000f_ffff, 32'h0010_0000, 32'h007f_ffff, 32'h0080_0000,
      32'h01ff_ffff, 32'h0200_0000, 32'h027f_ffff, 32'h07ff_ffff, 32'h0800_0000, 32'h09ff_ffff,
      32'h0a00_0000, 32'h1600_0000, 32'h17ff_ffff, 32'h1800_05ff, 32'h1800_0600, 32'h1800_0608,
      32'h1800_0609, 32'h1800_2000, 32'h1800_2fff, 32'h1880_0000, 32'h188f_ffff, 32'h18c0_0000,
      32'h18ff_ffff, 32'h1fc0_0000, 32'h1fdf_ffff, 32'h1fe0_0000, 32'h1fff_ffff, 32'h4000_0000,
      32'h5fff_ffff, 32'h6000_0000, 32'h8000_0000};
   always #20 clk_i = ~clk_i;
   bad_bus_model u_bus (.clk_i(clk_i), .req_i(req), .req_addr_i(req_addr),
      .addr_valid_o(addr_valid), .addr_o(addr));
   bad_decoder dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_valid_i(addr_valid), .addr_i(addr),
      .cfg_sram_present_i(cfg_in[0]), .cfg_dimm_64mb_i(cfg_in[1]), .cfg_flash_i(cfg_in[2]),
      .cfg_pci_boot_i(cfg_in[3]), .cfg_dram_sdram_i(sd_in), .mem_cs_b_o(cs_b),
      .dram_bank_sel_o(bank), .dram_socket_sel_o(sock), .target_o(tgt), .progio_sel_o(progio),
      .miss_o(miss), .dram_base0_o(b0), .dram_base1_o(b1), .dram_base2_o(b2), .dram_base3_o(b3),
      .dram_mask_o(msk), .pcim3_base_o(m3), .dram_sdram_o(sdr));
   // Expected target code for an address under the captured straps.
   function automatic logic [3:0] ref_t(input logic [31:0] a);
      logic [31:0] top;
      top = cfg[2] ? 32'h1fdf_ffff : 32'h1fff_ffff;
      if (!cfg[3] && a inside {[32'h1fc0_0000:top]}) return 4'h1;
      if (cfg[0] && a <= 32'h000f_ffff) return 4'h2;
      if (a >= lo && a - lo < 4 * st) return 4'h4;
      if (a inside {[32'h1600_0000:32'h17ff_ffff]}) return 4'h3;
      if (a inside {[32'h1800_0600:32'h1800_0608]}) return 4'h5;
      if (a inside {[32'h1800_2000:32'h1800_2fff]}) return 4'h6;
      if (a inside {[32'h1880_0000:32'h188f_ffff]}) return 4'h7;
      if (a[31:22] == (cfg[3] ? 10'h07f : 10'h063)) return 4'ha;
      if (a[31:30] == 2'h1) return a[29] ? 4'h9 : 4'h8;
      return 4'h0;
   endfunction
   // Compares one value and counts the outcome.
   task automatic chk(input logic [31:0] v, input logic [31:0] e, input string m);
      compares++;
      if (v !== e) begin
         fails++;
         $display("wrong value at %0t: %s got %h expected %h", $time, m, v, e);
      end
   endtask
   // One bus access, then a look at the registered answer.
   task automatic acc(input logic [31:0] a);
      logic [3:0] t;
      t = ref_t(a);
      @(posedge clk_i) req <= 1'b1;
      req_addr <= a;
      @(posedge clk_i) req <= 1'b0;
      #1;
      chk(tgt, t, "target");
      chk(cs_b, t == 1 ? 6'h3e : t == 2 ? 6'h3d : t == 3 ? 6'h1f : 6'h3f, "select");
      chk(miss, t == 0, "miss");
      chk(progio, t == 5, "io controller");
      chk(bank, t == 4 ? 4'h1 << ((a - lo) / st) : 4'h0, "bank");
      chk(sock, t == 4 ? ((a - lo) / st < 2 ? 2'h1 : 2'h2) : 2'h0, "socket");
   endtask
   // Reset with new straps, then move the straps to prove they are ignored.
   task automatic rst(input logic [3:0] c);
      @(posedge clk_i) rst_b_i <= 1'b0;
      cfg_in <= c;
      sd_in <= ^c;
      cfg = c;
      st = c[1] ? 32'h0200_0000 : 32'h0080_0000;
      lo = c[0] ? st : 32'h0;
      repeat (12) @(posedge clk_i);
      rst_b_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      cfg_in <= ~c;
      sd_in <= ~(^c);
      @(posedge clk_i) #1;
      chk(b0, lo, "base0");
      chk(b1, lo + st, "base1");
      chk(b2, lo + 2 * st, "base2");
      chk(b3, lo + 3 * st, "base3");
      chk(msk, c[1] ? 32'hfe00_0000 : 32'hff80_0000, "mask");
      chk(m3, c[3] ? 32'h1fc0_0000 : 32'h18c0_0000, "mem3 base");
      chk(sdr, ^c, "dram type");
   endtask
   // Closing report and verdict.
   task end_of_test;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // Each strap setting walks every region boundary, then an idle cycle.
   initial begin
      for (int i = 0; i < 6; i++) begin
         rst(cf[i]);
         foreach (ad[j]) acc(ad[j]);
         @(posedge clk_i) #1;
         chk(cs_b, 6'h3f, "idle select");
         chk(miss, 1'b0, "idle miss");
         $display("test %0d done", i);
      end
      end_of_test;
   end
endmodule

// File: rtl/bad_decoder.sv
module bad_decoder
   import bad_pkg::*;
(
   // Clock and reset.
   input  wire logic        clk_i,
   input  wire logic        rst_b_i,
   // Address request.
   input  wire logic        addr_valid_i,
   input  wire logic [31:0] addr_i,
   // Static configuration straps.
   input  wire logic        cfg_sram_present_i,
   input  wire logic        cfg_dimm_64mb_i,
   input  wire logic        cfg_flash_i,
   input  wire logic        cfg_pci_boot_i,
   input  wire logic        cfg_dram_sdram_i,
   // Memory selects and decode results.
   output logic [5:0]       mem_cs_b_o,
   output logic [3:0]       dram_bank_sel_o,
   output logic [1:0]       dram_socket_sel_o,
   output logic [3:0]       target_o,
   output logic             progio_sel_o,
   output logic             miss_o,
   // DRAM controller and PCI space 3 setup echoed for the base registers.
   output logic [31:0]      dram_base0_o,
   output logic [31:0]      dram_base1_o,
   output logic [31:0]      dram_base2_o,
   output logic [31:0]      dram_base3_o,
   output logic [31:0]      dram_mask_o,
   output logic [31:0]      pcim3_base_o,
   output logic             dram_sdram_o
);
   // ---------------------------------------------------------------
   // Configuration capture
   // ---------------------------------------------------------------
   logic sram_reg;
   logic d64_reg;
   logic flash_reg;
   logic pboot_reg;
   logic sdram_reg;
   logic run_reg;

   // Run flag: low through reset, set on the first edge after release.
   // The straps below follow their pins until that edge and are frozen after
   // it, so a strap that is moved while the system runs cannot remap memory
   // under live traffic.
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         run_reg <= 1'b0;
      end else begin
         run_reg <= 1'b1;
      end
   end

   // Strap capture. These flops carry no reset of their own: they load on
   // every edge while reset holds and on the first edge after release, then keep their value.
   always_ff @(posedge clk_i) begin
      if (!run_reg) begin
         sram_reg  <= cfg_sram_present_i;
         d64_reg   <= cfg_dimm_64mb_i;
         flash_reg <= cfg_flash_i;
         pboot_reg <= cfg_pci_boot_i;
         sdram_reg <= cfg_dram_sdram_i;
      end
   end

   // ---------------------------------------------------------------
   // DRAM layout selection
   // ---------------------------------------------------------------
   // The SRAM strap moves the first bank up past the static RAM, and the
   // module size strap picks the bank stride and the mask. The memory type
   // strap takes no part here, so EDO and SDRAM modules share one map and
   // software sees the same addresses whichever type is fitted.
   wire logic [31:0] d_base   = sram_reg ? (d64_reg ? BAD_DRAM_S64_BASE : BAD_DRAM_S16_BASE)
                                         : (d64_reg ? BAD_DRAM_N64_BASE : BAD_DRAM_N16_BASE);
   wire logic [31:0] d_end    = sram_reg ? (d64_reg ? BAD_DRAM_S64_END : BAD_DRAM_S16_END)
                                         : (d64_reg ? BAD_DRAM_N64_END : BAD_DRAM_N16_END);
   wire logic [31:0] d_stride = d64_reg ? BAD_STRIDE_64 : BAD_STRIDE_16;
   wire logic [31:0] d_mask   = d64_reg ? BAD_MASK_64 : BAD_MASK_16;
   // PCI memory space 3 follows the boot source strap.
   wire logic [31:0] m3_base  = pboot_reg ? BAD_PCIM3B_LO : BAD_PCIM3_LO;
   wire logic [31:0] m3_end   = pboot_reg ? BAD_PCIM3B_HI : BAD_PCIM3_HI;

   // Four bank bases and per-bank hits; the layout is type-independent.
   logic [31:0] bank_base [BAD_NUM_BANKS];
   logic [3:0]  bank_hit;
   genvar gi;
   generate
      for (gi = 0; gi < BAD_NUM_BANKS; gi++) begin : g_bank
         // Base of bank gi; the index is cast so the product stays 32 bits.
         assign bank_base[gi] = d_base + d_stride * 32'(gi);
         // A bank hits when the address bits kept by the mask match its base.
         assign bank_hit[gi]  = ((addr_i & d_mask) == bank_base[gi]);
      end
   endgenerate

   // ---------------------------------------------------------------
   // Region decode
   // ---------------------------------------------------------------
   // Flash fills only the lower half of the boot range; the upper half misses.
   wire logic boot_hi_ok = flash_reg ? (addr_i <= BAD_FLASH_HI) : (addr_i <= BAD_BOOT_HI);
   wire logic hit_pcim3  = (addr_i >= m3_base) && (addr_i <= m3_end);
   // On PCI boot space 3 owns the boot range, so the boot select stands aside.
   wire logic hit_boot   = !pboot_reg && (addr_i >= BAD_BOOT_LO) && boot_hi_ok;
   wire logic hit_sram   = sram_reg && (addr_i <= BAD_SRAM_HI);
   wire logic hit_scc    = (addr_i >= BAD_SCC_LO) && (addr_i <= BAD_SCC_HI);
   wire logic hit_dram   = (addr_i >= d_base) && (addr_i <= d_end);
   // The I/O controller window is short and unaligned, so both ends are compared.
   wire logic hit_progio = (addr_i >= BAD_PROGIO_LO) && (addr_i <= BAD_PROGIO_HI);

   // ---------------------------------------------------------------
   // PCI interface windows
   // ---------------------------------------------------------------
   // Internal registers, I/O space and the two large memory spaces.
   wire logic hit_preg   = (addr_i >= BAD_PCIREG_LO) && (addr_i <= BAD_PCIREG_HI);
   wire logic hit_pciio  = (addr_i >= BAD_PCIIO_LO) && (addr_i <= BAD_PCIIO_HI);
   wire logic hit_m1     = (addr_i >= BAD_PCIM1_LO) && (addr_i <= BAD_PCIM1_HI);
   wire logic hit_m2     = (addr_i >= BAD_PCIM2_LO) && (addr_i <= BAD_PCIM2_HI);

   // Priority encode to a single target so only one select can be active.
   // Boot comes first, then the static RAM and DRAM, then the fixed device
   // windows and last the PCI spaces. None of the ranges overlap today, so
   // the order only matters if a strap setting is ever added that makes two
   // of them meet.
   bad_tgt_e tgt;
   always_comb begin
      tgt = BAD_T_NONE;
      if (!addr_valid_i) tgt = BAD_T_NONE;
      else if (hit_boot) tgt = BAD_T_BOOT;
      else if (hit_sram) tgt = BAD_T_SRAM;
      else if (hit_dram) tgt = BAD_T_DRAM;
      else if (hit_scc) tgt = BAD_T_SCC;
      else if (hit_progio) tgt = BAD_T_PROGIO;
      else if (hit_preg) tgt = BAD_T_PCIREG;
      else if (hit_pciio) tgt = BAD_T_PCIIO;
      else if (hit_pcim3) tgt = BAD_T_PCIM3;
      else if (hit_m1) tgt = BAD_T_PCIM1;
      else if (hit_m2) tgt = BAD_T_PCIM2;
   end

   // Selects are active low; lines 2 to 4 have no user on this board.
   wire logic [5:0] cs_next = {~(tgt == BAD_T_SCC), 3'h7, ~(tgt == BAD_T_SRAM),
                               ~(tgt == BAD_T_BOOT)};
   // Bank selects only stand for a DRAM access; other targets clear them.
   wire logic [3:0] bank_next = (tgt == BAD_T_DRAM) ? bank_hit : 4'h0;
   // Sockets: banks 0-1 on socket 0, banks 2-3 on socket 1.
   wire logic [1:0] sock_next = {|bank_next[3:2], |bank_next[1:0]};

   // ---------------------------------------------------------------
   // Registered outputs
   // ---------------------------------------------------------------
   // Chip selects, negated during reset so no device is enabled early.
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         mem_cs_b_o <= BAD_CS_IDLE;
      end else begin
         mem_cs_b_o <= cs_next;
      end
   end

   // DRAM bank and socket selects.
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         dram_bank_sel_o   <= 4'h0;
         dram_socket_sel_o <= 2'h0;
      end else begin
         dram_bank_sel_o   <= bank_next;
         dram_socket_sel_o <= sock_next;
      end
   end

   // Target code and the I/O controller and miss flags. A miss is only
   // flagged for a real request, never for an idle bus.
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         target_o     <= 4'h0;
         progio_sel_o <= 1'b0;
         miss_o       <= 1'b0;
      end else begin
         target_o     <= tgt;
         progio_sel_o <= (tgt == BAD_T_PROGIO);
         miss_o       <= addr_valid_i && (tgt == BAD_T_NONE);
      end
   end

   // ---------------------------------------------------------------
   // Setup values
   // ---------------------------------------------------------------
   // Setup values for the DRAM and PCI base registers. They follow the
   // frozen straps, so they settle one edge after the straps do and then
   // stand still until the next reset.
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         dram_base0_o <= 32'h0;
         dram_base1_o <= 32'h0;
         dram_base2_o <= 32'h0;
         dram_base3_o <= 32'h0;
         dram_mask_o  <= 32'h0;
         pcim3_base_o <= 32'h0;
         dram_sdram_o <= 1'b0;
      end else begin
         dram_base0_o <= bank_base[0];
         dram_base1_o <= bank_base[1];
         dram_base2_o <= bank_base[2];
         dram_base3_o <= bank_base[3];
         dram_mask_o  <= d_mask;
         pcim3_base_o <= m3_base;
         dram_sdram_o <= sdram_reg;
      end
   end
endmodule

// File: rtl/bad_pkg.sv
package bad_pkg;
   // ---------------------------------------------------------------
   // Address ranges, given as inclusive low and high bounds.
   // ---------------------------------------------------------------
   localparam logic [31:0] BAD_BOOT_LO     = 32'h1fc0_0000;
   localparam logic [31:0] BAD_BOOT_HI     = 32'h1fff_ffff;
   localparam logic [31:0] BAD_FLASH_HI    = 32'h1fdf_ffff;
   localparam logic [31:0] BAD_SRAM_LO     = 32'h0000_0000;
   localparam logic [31:0] BAD_SRAM_HI     = 32'h000f_ffff;
   localparam logic [31:0] BAD_SCC_LO      = 32'h1600_0000;
   localparam logic [31:0] BAD_SCC_HI      = 32'h17ff_ffff;
   localparam logic [31:0] BAD_PROGIO_LO   = 32'h1800_0600;
   localparam logic [31:0] BAD_PROGIO_HI   = 32'h1800_0608;
   localparam logic [31:0] BAD_PCIREG_LO   = 32'h1800_2000;
   localparam logic [31:0] BAD_PCIREG_HI   = 32'h1800_2fff;
   localparam logic [31:0] BAD_PCIIO_LO    = 32'h1880_0000;
   localparam logic [31:0] BAD_PCIIO_HI    = 32'h188f_ffff;
   localparam logic [31:0] BAD_PCIM1_LO    = 32'h4000_0000;
   localparam logic [31:0] BAD_PCIM1_HI    = 32'h5fff_ffff;
   localparam logic [31:0] BAD_PCIM2_LO    = 32'h6000_0000;
   localparam logic [31:0] BAD_PCIM2_HI    = 32'h7fff_ffff;
   localparam logic [31:0] BAD_PCIM3_LO    = 32'h18c0_0000;
   localparam logic [31:0] BAD_PCIM3_HI    = 32'h18ff_ffff;
   localparam logic [31:0] BAD_PCIM3B_LO   = 32'h1fc0_0000;
   localparam logic [31:0] BAD_PCIM3B_HI   = 32'h1fff_ffff;
   // ---------------------------------------------------------------
   // DRAM layouts: first bank base, bank stride, mask, region end.
   // ---------------------------------------------------------------
   localparam logic [31:0] BAD_DRAM_S16_BASE = 32'h0080_0000;
   localparam logic [31:0] BAD_DRAM_S16_END  = 32'h027f_ffff;
   localparam logic [31:0] BAD_DRAM_S64_BASE = 32'h0200_0000;
   localparam logic [31:0] BAD_DRAM_S64_END  = 32'h09ff_ffff;
   localparam logic [31:0] BAD_DRAM_N16_BASE = 32'h0000_0000;
   localparam logic [31:0] BAD_DRAM_N16_END  = 32'h01ff_ffff;
   localparam logic [31:0] BAD_DRAM_N64_BASE = 32'h0000_0000;
   localparam logic [31:0] BAD_DRAM_N64_END  = 32'h07ff_ffff;
   localparam logic [31:0] BAD_STRIDE_16     = 32'h0080_0000;
   localparam logic [31:0] BAD_STRIDE_64     = 32'h0200_0000;
   localparam logic [31:0] BAD_MASK_16       = 32'hff80_0000;
   localparam logic [31:0] BAD_MASK_64       = 32'hfe00_0000;
   localparam int          BAD_NUM_BANKS     = 4;
   localparam int          BAD_NUM_SOCKETS   = 2;
   localparam int          BAD_PROGIO_PINS   = 12;
   localparam int          BAD_NUM_CS        = 6;
   // Reset values of the select outputs (all negated).
   localparam logic [5:0]  BAD_CS_IDLE       = 6'h3f;
   // Target codes shown on the region output.
   typedef enum logic [3:0] {
      BAD_T_NONE, BAD_T_BOOT, BAD_T_SRAM, BAD_T_SCC, BAD_T_DRAM, BAD_T_PROGIO,
      BAD_T_PCIREG, BAD_T_PCIIO, BAD_T_PCIM1, BAD_T_PCIM2, BAD_T_PCIM3
   } bad_tgt_e;
endpackage
